// [psrst_pkg.sv]
// psrst_pkg: register map, field positions and reset values of the soft-reset block
// assumes a 32-bit register port with byte offsets
package psrst_pkg;
	localparam logic [11:0] PSRST_OFS_PERIPH   = 12'h044;
	localparam logic [11:0] PSRST_OFS_PORT     = 12'h048;
	localparam logic [11:0] PSRST_OFS_CAP_TWO  = 12'h014;
	localparam logic [11:0] PSRST_OFS_CAP_FOUR = 12'h01c;

	localparam int PSRST_BIT_ASYNC0 = 0;
	localparam int PSRST_BIT_ASYNC1 = 1;
	localparam int PSRST_BIT_SYNC0  = 4;
	localparam int PSRST_BIT_TWI0   = 12;
	localparam int PSRST_BIT_TMR0   = 16;
	localparam int PSRST_BIT_TMR1   = 17;
	localparam int PSRST_BIT_TMR2   = 18;
	localparam int PSRST_BIT_COMPARATOR_ZERO_RESET  = 24;
	localparam int PSRST_NUM_PORTS  = 5;

	// implemented bits; everything else reads zero
	localparam logic [31:0] PSRST_PERIPH_IMPL = 32'h0107_1013;
	localparam logic [31:0] PSRST_PORT_IMPL   = 32'h0000_001f;

	localparam logic [31:0] PSRST_PERIPH_RESET = 32'h0000_0000;
	localparam logic [31:0] PSRST_PORT_RESET   = 32'h0000_0000;
	localparam logic [31:0] PSRST_CAP_TWO_DEF  = 32'h0107_1013;
	localparam logic [31:0] PSRST_CAP_FOUR_DEF = 32'h0000_001f;
endpackage

// [psrst_wr_if.sv]
// psrst_wr_if: masked write request from the bus decoder to a reset register
// assumes a single clock domain
`timescale 1ns/10ps
`default_nettype none
interface psrst_wr_if;
	logic        en;
	logic [31:0] data;
	logic [31:0] mask;
	logic [31:0] value;
	modport src (output en, output data, output mask, input value);
	modport dst (input en, input data, input mask, output value);
endinterface
`default_nettype wire

// [psrst_mreg.sv]
// psrst_mreg: one 32-bit reset-control register with capability-masked writes
// assumes write request and mask are stable in the write cycle
`timescale 1ns/10ps
`default_nettype none
module psrst_mreg
	import psrst_pkg::*;
#(
	parameter logic [31:0] IMPL  = 32'hffff_ffff,
	parameter logic [31:0] RESET = 32'h0000_0000
) (
	input  wire logic   i_ref_clk,
	input  wire logic   i_rst_n,
	psrst_wr_if.dst     wr
);
	typedef struct packed {
		logic [31:0] bits;
	} psrst_mreg_t;

	psrst_mreg_t st;
	psrst_mreg_t next_st;

	always_comb begin
		next_st = st;
		// only capable, implemented bits move; other implemented bits keep their value, unimplemented bits are forced to zero
		if (wr.en) begin
			next_st.bits = (st.bits & ~(wr.mask & IMPL)) | (wr.data & wr.mask & IMPL);
		end
		next_st.bits = next_st.bits & IMPL;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '{bits: RESET};
		end else begin
			st <= next_st;
		end
	end

	assign wr.value = st.bits;
endmodule // psrst_mreg
`default_nettype wire

// [psrst_top.sv]
// psrst_top: software reset controls for on-chip peripherals and GPIO ports
// assumes a one-cycle strobe register port; read data valid the cycle after the read strobe
// assumes capability words are fixed when the block is built; software cannot write them
// Notes on behaviour
// - peripheral register writes masked by capability two
// - port register writes masked by capability four
// - both registers clear at system reset
// - bit 4 resets synchronous serial zero
// - bits 1,0 reset asynchronous serial one, zero
// - port bits 4..0 reset ports E..A
// - unassigned bits read as zero
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module psrst_top
	import psrst_pkg::*;
#(
	parameter logic [31:0] CAP_TWO_VALUE  = PSRST_CAP_TWO_DEF,
	parameter logic [31:0] CAP_FOUR_VALUE = PSRST_CAP_FOUR_DEF
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rstn,
	input  wire logic [11:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output var  logic [31:0] o_rdata,
	output var  logic        o_comparator_zero_reset,
	output var  logic        o_gp_timer_zero_reset,
	output var  logic        o_gp_timer_one_reset,
	output var  logic        o_gp_timer_two_reset,
	output var  logic        o_two_wire_unit_zero_reset,
	output var  logic        o_sync_serial_zero_reset,
	output var  logic        o_async_serial_zero_reset,
	output var  logic        o_async_serial_one_reset,
	output var  logic [4:0]  o_port_reset
);
	// one flop per unit control, named after the unit it holds in reset
	typedef struct packed {
		logic comparator_zero;
		logic gp_timer_two;
		logic gp_timer_one;
		logic gp_timer_zero;
		logic two_wire_unit_zero;
		logic sync_serial_zero;
		logic async_serial_one;
		logic async_serial_zero;
	} psrst_periph_ctl_t;

	typedef struct packed {
		logic [31:0]                rdata;
		psrst_periph_ctl_t          periph_out;
		logic [PSRST_NUM_PORTS-1:0] port_out;
	} psrst_top_t;

	// the synchroniser is the only state cleared straight from the pin; it stays
	// outside the struct because everything else is cleared by its output
	logic [1:0] rst_sync;
	logic       rst_n;

	psrst_top_t st;
	psrst_top_t next_st;

	// address decode, shared by the write enables and the read mux
	logic       hit_periph;
	logic       hit_port;
	logic       hit_cap_two;
	logic       hit_cap_four;

	psrst_wr_if periph_wr ();
	psrst_wr_if port_wr ();

	function automatic logic psrst_hit(
		input logic [11:0] addr,
		input logic [11:0] ofs
	);
		return addr == ofs;
	endfunction

	// bus view of a register; nothing outside the implemented bits can leak out
	function automatic logic [31:0] psrst_visible(
		input logic [31:0] value,
		input logic [31:0] impl
	);
		return value & impl;
	endfunction

	// gathers the eight unit controls in output order, comparator first
	function automatic psrst_periph_ctl_t psrst_periph_pick(
		input logic [31:0] value
	);
		psrst_periph_ctl_t pick;
		pick.comparator_zero    = value[PSRST_BIT_COMPARATOR_ZERO_RESET];
		pick.gp_timer_two       = value[PSRST_BIT_TMR2];
		pick.gp_timer_one       = value[PSRST_BIT_TMR1];
		pick.gp_timer_zero      = value[PSRST_BIT_TMR0];
		pick.two_wire_unit_zero = value[PSRST_BIT_TWI0];
		pick.sync_serial_zero   = value[PSRST_BIT_SYNC0];
		pick.async_serial_one   = value[PSRST_BIT_ASYNC1];
		pick.async_serial_zero  = value[PSRST_BIT_ASYNC0];
		return pick;
	endfunction

	// port controls, bit 4 port E down to bit 0 port A
	function automatic logic [PSRST_NUM_PORTS-1:0] psrst_port_pick(
		input logic [31:0] value
	);
		return value[PSRST_NUM_PORTS-1:0];
	endfunction

	// read mux; a read of an unmapped offset and a cycle with no read both give zero
	function automatic logic [31:0] psrst_read_mux(
		input logic        rd,
		input logic        sel_periph,
		input logic        sel_port,
		input logic        sel_cap_two,
		input logic        sel_cap_four,
		input logic [31:0] periph_value,
		input logic [31:0] port_value
	);
		logic [31:0] data;
		data = 32'h0000_0000;
		if (rd) begin
			if (sel_periph) begin
				data = psrst_visible(periph_value, PSRST_PERIPH_IMPL);
			end else if (sel_port) begin
				data = psrst_visible(port_value, PSRST_PORT_IMPL);
			end else if (sel_cap_two) begin
				// capability words read back so software can see which bits are live
				data = CAP_TWO_VALUE;
			end else if (sel_cap_four) begin
				data = CAP_FOUR_VALUE;
			end
		end
		return data;
	endfunction

	// release through two flops; assertion stays asynchronous so a held pin
	// clears the block even while the clock is stopped
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// capability words are decoded for reads only
	assign hit_periph   = psrst_hit(i_addr, PSRST_OFS_PERIPH);
	assign hit_port     = psrst_hit(i_addr, PSRST_OFS_PORT);
	assign hit_cap_two  = psrst_hit(i_addr, PSRST_OFS_CAP_TWO);
	assign hit_cap_four = psrst_hit(i_addr, PSRST_OFS_CAP_FOUR);

	// both registers share one write path; only the mask and the implemented set differ
	assign periph_wr.en   = i_wr && hit_periph;
	assign periph_wr.data = i_wdata;
	assign periph_wr.mask = CAP_TWO_VALUE;
	assign port_wr.en     = i_wr && hit_port;
	assign port_wr.data   = i_wdata;
	assign port_wr.mask   = CAP_FOUR_VALUE;

	psrst_mreg #(
		.IMPL  (PSRST_PERIPH_IMPL),
		.RESET (PSRST_PERIPH_RESET)
	) u_periph (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (rst_n),
		.wr        (periph_wr)
	);

	psrst_mreg #(
		.IMPL  (PSRST_PORT_IMPL),
		.RESET (PSRST_PORT_RESET)
	) u_port (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (rst_n),
		.wr        (port_wr)
	);

	always_comb begin
		next_st = st;
		next_st.rdata = psrst_read_mux(
			i_rd,
			hit_periph,
			hit_port,
			hit_cap_two,
			hit_cap_four,
			periph_wr.value,
			port_wr.value
		);
		// outputs follow the registers one cycle later, all from flops
		next_st.periph_out = psrst_periph_pick(periph_wr.value);
		next_st.port_out   = psrst_port_pick(port_wr.value);
	end

	// read data lives for one cycle only; the mux gives zero when no read is taken
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st.rdata      <= 32'h0000_0000;
			st.periph_out <= '0;
			st.port_out   <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata                    = st.rdata;
	// high holds the unit in software reset
	assign o_comparator_zero_reset    = st.periph_out.comparator_zero;
	assign o_gp_timer_two_reset       = st.periph_out.gp_timer_two;
	assign o_gp_timer_one_reset       = st.periph_out.gp_timer_one;
	assign o_gp_timer_zero_reset      = st.periph_out.gp_timer_zero;
	assign o_two_wire_unit_zero_reset = st.periph_out.two_wire_unit_zero;
	assign o_sync_serial_zero_reset   = st.periph_out.sync_serial_zero;
	assign o_async_serial_one_reset   = st.periph_out.async_serial_one;
	assign o_async_serial_zero_reset  = st.periph_out.async_serial_zero;

	// bit 4 port E down to bit 0 port A
	assign o_port_reset               = st.port_out;
endmodule // psrst_top
`default_nettype wire

// [psrst_chk.sv]
// psrst_chk: port assertions for psrst_top
// assumes the bind hands on the capability parameters
`timescale 1ns/10ps
`default_nettype none
module psrst_chk
	import psrst_pkg::*;
#(
	parameter logic [31:0] CAP_TWO_VALUE  = PSRST_CAP_TWO_DEF,
	parameter logic [31:0] CAP_FOUR_VALUE = PSRST_CAP_FOUR_DEF
) (
	input wire logic        i_ref_clk,
	input wire logic        i_rstn,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic        o_comparator_zero_reset,
	input wire logic        o_gp_timer_zero_reset,
	input wire logic        o_gp_timer_one_reset,
	input wire logic        o_gp_timer_two_reset,
	input wire logic        o_two_wire_unit_zero_reset,
	input wire logic        o_sync_serial_zero_reset,
	input wire logic        o_async_serial_zero_reset,
	input wire logic        o_async_serial_one_reset,
	input wire logic [4:0]  o_port_reset
);
	// outputs folded back into register layout
	wire logic [31:0] pv = {7'h00, o_comparator_zero_reset, 5'h00, o_gp_timer_two_reset, o_gp_timer_one_reset,
		o_gp_timer_zero_reset, 3'h0, o_two_wire_unit_zero_reset, 7'h00, o_sync_serial_zero_reset, 2'h0,
		o_async_serial_one_reset, o_async_serial_zero_reset};
	wire logic wp = i_wr && i_addr == PSRST_OFS_PERIPH;
	wire logic wq = i_wr && i_addr == PSRST_OFS_PORT;
	wire logic rp = i_rd && i_addr == PSRST_OFS_PERIPH;
	wire logic rq = i_rd && i_addr == PSRST_OFS_PORT;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	property p_per; wp ##2 1 |-> pv == ($past(i_wdata, 2) & CAP_TWO_VALUE & PSRST_PERIPH_IMPL); endproperty
	a_per: assert property (p_per) else $error("peripheral write mask");
	property p_port; wq ##2 1 |-> o_port_reset == ($past(i_wdata[4:0], 2) & CAP_FOUR_VALUE[4:0]); endproperty
	a_port: assert property (p_port) else $error("port write mask");
	property p_rst; $rose(i_rstn) |-> (pv == 32'h0 && o_port_reset == 5'h0) [*2]; endproperty
	a_rst: assert property (p_rst) else $error("not clear after reset");
	property p_sync; wp ##2 1 |-> o_sync_serial_zero_reset == ($past(i_wdata[4], 2) & CAP_TWO_VALUE[4]); endproperty
	a_sync: assert property (p_sync) else $error("sync serial control");
	property p_rdp; rp |=> o_rdata == pv; endproperty
	a_rdp: assert property (p_rdp) else $error("peripheral readback");
	property p_rdq; rq |=> o_rdata == {27'h0, o_port_reset}; endproperty
	a_rdq: assert property (p_rdq) else $error("port readback");
	property p_rsv; rp |=> (o_rdata & ~PSRST_PERIPH_IMPL) == 32'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	property p_hold; !wp |-> ##2 $stable(pv); endproperty
	a_hold: assert property (p_hold) else $error("control changed unwritten");
	c_wp: cover property (wp ##2 pv != 32'h0);
	c_rq: cover property (rq ##1 o_rdata != 32'h0);
	c_rst: cover property ($rose(i_rstn));
endmodule // psrst_chk
bind psrst_top psrst_chk #(.CAP_TWO_VALUE(CAP_TWO_VALUE), .CAP_FOUR_VALUE(CAP_FOUR_VALUE)) u_chk (.*);
`default_nettype wire

// [tb_top.sv]
// tb_top: register-port bench for psrst_top
// assumes reduced capability masks so write masking shows
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
	import psrst_pkg::*;
	localparam logic [31:0] C2 = 32'h0105_1012;
	localparam logic [31:0] C4 = 32'h0000_001b;
	logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [11:0] i_addr = 12'h000;
	logic [31:0] i_wdata = 32'h0, o_rdata, d;
	logic o_comparator_zero_reset, o_gp_timer_zero_reset, o_gp_timer_one_reset, o_gp_timer_two_reset;
	logic o_two_wire_unit_zero_reset, o_sync_serial_zero_reset, o_async_serial_zero_reset, o_async_serial_one_reset;
	logic [4:0] o_port_reset;
	wire logic [7:0] pr = {o_comparator_zero_reset, o_gp_timer_two_reset, o_gp_timer_one_reset, o_gp_timer_zero_reset,
		o_two_wire_unit_zero_reset, o_sync_serial_zero_reset, o_async_serial_one_reset, o_async_serial_zero_reset};
	int err_total = 0, checks_done = 0, cyc = 0;
	// address, write data, expected readback
	logic [75:0] rows [7] = '{{12'h044, 32'hffff_ffff, C2}, {12'h048, 32'hffff_ffff, C4},
		{12'h044, 32'h0102_0011, 32'h0100_0010}, {12'h048, 32'h0000_0015, 32'h0000_0011},
		{12'h014, 32'h0000_0000, C2}, {12'h01c, 32'hffff_ffff, C4}, {12'h0fc, 32'haaaa_aaaa, 32'h0}};
	psrst_top #(.CAP_TWO_VALUE(C2), .CAP_FOUR_VALUE(C4)) dut (.*);
	always #50 i_ref_clk = ~i_ref_clk;
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		v = o_rdata;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// run needs about 56 cycles
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 400) begin
			err_total++;
			stop_test;
		end
	end
	initial begin
		repeat (2) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		rd(PSRST_OFS_PERIPH, d);
		`CHK(d, PSRST_PERIPH_RESET)
		rd(PSRST_OFS_PORT, d);
		`CHK(d, PSRST_PORT_RESET)
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i][75:64], rows[i][63:32]);
			rd(rows[i][75:64], d);
			`CHK(d, rows[i][31:0])
		end
		$display("table test done");
		// write then read with no gap between strobes
		@(posedge i_ref_clk);
		i_addr <= PSRST_OFS_PERIPH;
		i_wdata <= 32'h0005_1013;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		`CHK(o_rdata, 32'h0005_1012)
		`CHK(pr, 8'h5e)
		wr(PSRST_OFS_PORT, 32'h0000_001f);
		// reset pins follow the register one edge after the write lands
		repeat (2) @(negedge i_ref_clk);
		`CHK(o_port_reset, 5'h1b)
		$display("back to back test done");
		rd(PSRST_OFS_PERIPH, d);
		wr(PSRST_OFS_PERIPH, d | 32'h0100_0000);
		rd(PSRST_OFS_PERIPH, d);
		`CHK(d, 32'h0105_1012)
		`CHK(pr, 8'hde)
		$display("read-modify-write test done");
		@(posedge i_ref_clk);
		i_rstn <= 1'b0;
		@(negedge i_ref_clk);
		`CHK({pr, o_port_reset}, 13'h0)
		@(posedge i_ref_clk);
		i_rstn <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		rd(PSRST_OFS_PERIPH, d);
		`CHK(d, PSRST_PERIPH_RESET)
		rd(PSRST_OFS_PORT, d);
		`CHK(d, PSRST_PORT_RESET)
		`CHK({pr, o_port_reset}, 13'h0)
		$display("mid-run reset test done");
		stop_test;
	end
endmodule // tb_top
`default_nettype wire
